// [sec_arb_pkg.sv]
package sec_arb_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register offsets on the configuration port
    localparam logic [7:0] ADDR_ARB_CTRL   = 8'hDC;
    localparam logic [7:0] ADDR_REQ_BLOCK  = 8'hDD;
    localparam logic [7:0] ADDR_TO_FLAGS   = 8'hDE;

    ////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int PARK_BIT         = 7;
    localparam int BRIDGE_TIER_BIT  = 6;
    localparam int TIMEOUT_EN_BIT   = 7;
    localparam int AUTO_BLOCK_BIT   = 6;
    localparam int NUM_REQ          = 6;
    localparam int NUM_OWNERS       = 7;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [7:0] ARB_CTRL_RST    = 8'h7F;
    localparam logic [7:0] REQ_BLOCK_RST   = 8'h00;
    localparam logic [5:0] TO_FLAGS_RST    = 6'h00;
    localparam logic [7:0] READ_IDLE_VAL   = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // owners: 0..5 are external request inputs, 6 is the bridge itself
    localparam logic [2:0] BRIDGE_ID       = 3'h6;

    ////////////////////////////////////////////////////////////////////////////
    // timing: time-out given directly in bus clocks
    localparam int TIMEOUT_CLKS            = 16;
    localparam int TIMEOUT_CYCLES          = TIMEOUT_CLKS;
    localparam logic [4:0] TIMEOUT_LAST    = 5'(TIMEOUT_CYCLES - 1);

endpackage

// [timeout_timer.sv]
module timeout_timer
(
    // clock and reset
    input  wire logic   sys_clk,
    input  wire logic   rst,
    input  wire logic   ce,
    // control
    input  wire logic   run,
    input  wire logic   restart,
    // event
    output logic        expired
);
    import sec_arb_pkg::*;

    typedef struct packed {
        logic [4:0] cnt_r;
    } timer_state_t;

    timer_state_t st_r;
    timer_state_t st_nxt;

    // expiry is a same-cycle strobe so the caller still sees the owner it belongs to
    assign expired = ce && run && !restart && (st_r.cnt_r == TIMEOUT_LAST); // R2

    always_comb
    begin
        st_nxt = st_r;
        if (restart || !run)
            st_nxt.cnt_r = 5'h00; // R13
        else if (st_r.cnt_r == TIMEOUT_LAST)
            st_nxt.cnt_r = 5'h00;
        else
            st_nxt.cnt_r = st_r.cnt_r + 5'h01; // R1
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            st_r <= '0;
        else if (ce)
            st_r <= st_nxt;
    end

endmodule // timeout_timer

// [sec_bus_arbiter.sv]
// Summary of operation
// R1 - with time-out enabled, count 16 bus clocks of idle bus per grant; disabled by default
// R2 - no FRAME when the count runs out means the granted master timed out
// R3 - with auto blocking on, a timed-out request input is no longer honoured
// R4 - a set block bit makes the arbiter ignore that request input
// R5 - a time-out sets the status bit at the request input's position
// R6 - status bits stay set until software writes one; zero leaves them
// R7 - software clears auto blocking before writing one to clear a status bit
// R8 - the top two status bits always read zero
// R9 - every control and status bit returns to reset value on any reset
// R10 - two rotating tiers; the high tier wins over the low tier
// R11 - each grant line and the bridge has a tier bit, high after reset
// R12 - with no requests, park on last master, or on the bridge if parking set; here a blocked last master also parks the bus on the bridge
// R13 - time-out count restarts per grant and stops once FRAME is seen
module sec_bus_arbiter
(
    // clock, enable and resets
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic        fund_reset_in,
    input  wire logic        global_reset_in,
    input  wire logic        por_reset_in,
    // secondary bus pins
    input  wire logic [5:0]  req_n,
    input  wire logic        frame_n,
    input  wire logic        irdy_n,
    output logic      [5:0]  gnt_n,
    // bridge as a master
    input  wire logic        bridge_req,
    output logic             bridge_gnt,
    // configuration register port
    input  wire logic [7:0]  cfg_addr,
    input  wire logic        cfg_wr,
    input  wire logic [7:0]  cfg_wdata,
    input  wire logic        cfg_rd,
    output logic      [7:0]  cfg_rdata
);
    import sec_arb_pkg::*;

    typedef struct packed {
        logic [5:0] req_s1_r;
        logic [5:0] req_s2_r;
        logic       frame_s1_r;
        logic       frame_s2_r;
        logic       irdy_s1_r;
        logic       irdy_s2_r;
        logic [7:0] ctrl_r;
        logic [7:0] block_r;
        logic [5:0] flags_r;
        logic [2:0] owner_r;
        logic [2:0] last_r;
        logic [5:0] gnt_n_r;
        logic       bridge_gnt_r;
        logic [7:0] rdata_r;
    } arb_state_t;

    arb_state_t st_r;
    arb_state_t st_nxt;

    logic       any_rst;
    logic       bus_idle;
    logic [5:0] blk_eff;
    logic [6:0] req_all;
    logic [6:0] tier_hi;
    logic [3:0] pick_hi;
    logic [3:0] pick_lo;
    logic [2:0] park_id;
    logic [2:0] owner_nxt;
    logic       tmo_run;
    logic       tmo_restart;
    logic       tmo_hit;
    logic [5:0] owner_onehot;
    logic [5:0] flag_set;
    logic [5:0] flag_clr;

    // round robin among the set bits, starting just after the previous user
    function automatic logic [3:0] rr_pick(input logic [6:0] reqs, input logic [2:0] last);
        logic [3:0] res;
        int         idx;
        res = 4'h0;
        for (int i = NUM_OWNERS; i >= 1; i--)
        begin
            idx = (int'(last) + i) % NUM_OWNERS;
            if (reqs[idx])
                res = {1'b1, 3'(idx)};
        end
        return res;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // arbitration

    assign any_rst  = rst || fund_reset_in || global_reset_in || por_reset_in; // R9
    assign bus_idle = st_r.frame_s2_r && st_r.irdy_s2_r;

    assign blk_eff = st_r.block_r[5:0]
                   | (st_r.block_r[AUTO_BLOCK_BIT] ? st_r.flags_r : 6'h00); // R3 R4
    assign req_all = {bridge_req, ~st_r.req_s2_r & ~blk_eff};
    assign tier_hi = {st_r.ctrl_r[BRIDGE_TIER_BIT], st_r.ctrl_r[5:0]}; // R11
    assign pick_hi = rr_pick(req_all & tier_hi, st_r.last_r); // R10
    assign pick_lo = rr_pick(req_all & ~tier_hi, st_r.last_r); // R10

    // a blocked last master is not parked on; the bus goes to the bridge instead
    assign park_id = (st_r.ctrl_r[PARK_BIT] || (st_r.last_r != BRIDGE_ID && blk_eff[st_r.last_r]))
                   ? BRIDGE_ID : st_r.last_r; // R12

    always_comb
    begin
        owner_nxt = st_r.owner_r;
        if (bus_idle)
        begin
            if (pick_hi[3])
                owner_nxt = pick_hi[2:0]; // R10
            else if (pick_lo[3])
                owner_nxt = pick_lo[2:0];
            else
                owner_nxt = park_id; // R12
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // time-out watchdog

    assign tmo_run = st_r.block_r[TIMEOUT_EN_BIT] && bus_idle
                   && (st_r.owner_r != BRIDGE_ID) && req_all[st_r.owner_r]; // R1 R13
    assign tmo_restart = (owner_nxt != st_r.owner_r); // R13

    timeout_timer u_timer
    (
        .sys_clk (sys_clk),
        .rst     (any_rst),
        .ce      (ce),
        .run     (tmo_run),
        .restart (tmo_restart),
        .expired (tmo_hit)
    );

    always_comb
    begin
        owner_onehot = 6'h00;
        if (st_r.owner_r != BRIDGE_ID)
            owner_onehot[st_r.owner_r] = 1'b1;
    end

    assign flag_set = tmo_hit ? owner_onehot : 6'h00; // R5
    // clears are held off while auto blocking is on, so a blocked master stays out
    assign flag_clr = (cfg_wr && cfg_addr == ADDR_TO_FLAGS && !st_r.block_r[AUTO_BLOCK_BIT])
                    ? cfg_wdata[5:0] : 6'h00; // R6 R7

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        st_nxt            = st_r;
        st_nxt.req_s1_r   = req_n;
        st_nxt.req_s2_r   = st_r.req_s1_r;
        st_nxt.frame_s1_r = frame_n;
        st_nxt.frame_s2_r = st_r.frame_s1_r;
        st_nxt.irdy_s1_r  = irdy_n;
        st_nxt.irdy_s2_r  = st_r.irdy_s1_r;

        if (cfg_wr && cfg_addr == ADDR_ARB_CTRL)
            st_nxt.ctrl_r = cfg_wdata;
        if (cfg_wr && cfg_addr == ADDR_REQ_BLOCK)
            st_nxt.block_r = cfg_wdata; // R4
        st_nxt.flags_r = (st_r.flags_r & ~flag_clr) | flag_set; // R6

        // a master that starts a frame becomes the rotation reference
        if (!st_r.frame_s2_r)
            st_nxt.last_r = st_r.owner_r;
        st_nxt.owner_r = owner_nxt;
        for (int i = 0; i < NUM_REQ; i++)
            st_nxt.gnt_n_r[i] = (owner_nxt != 3'(i));
        st_nxt.bridge_gnt_r = (owner_nxt == BRIDGE_ID);

        if (cfg_rd)
        begin
            case (cfg_addr)
                ADDR_ARB_CTRL:  st_nxt.rdata_r = st_r.ctrl_r;
                ADDR_REQ_BLOCK: st_nxt.rdata_r = st_r.block_r;
                ADDR_TO_FLAGS:  st_nxt.rdata_r = {2'b00, st_r.flags_r}; // R8
                default:        st_nxt.rdata_r = READ_IDLE_VAL;
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (any_rst)
        begin
            st_r              <= '0; // R9
            st_r.req_s1_r     <= 6'h3F;
            st_r.req_s2_r     <= 6'h3F;
            st_r.frame_s1_r   <= 1'b1;
            st_r.frame_s2_r   <= 1'b1;
            st_r.irdy_s1_r    <= 1'b1;
            st_r.irdy_s2_r    <= 1'b1;
            st_r.ctrl_r       <= ARB_CTRL_RST; // R11
            st_r.block_r      <= REQ_BLOCK_RST;
            st_r.flags_r      <= TO_FLAGS_RST;
            st_r.owner_r      <= BRIDGE_ID;
            st_r.last_r       <= BRIDGE_ID;
            st_r.gnt_n_r      <= 6'h3F;
            st_r.bridge_gnt_r <= 1'b1;
        end
        else if (ce)
            st_r <= st_nxt;
    end

    assign gnt_n      = st_r.gnt_n_r;
    assign bridge_gnt = st_r.bridge_gnt_r;
    assign cfg_rdata  = st_r.rdata_r;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    logic [4:0] run_len;
    logic [5:0] fell_bits;
    logic [5:0] flags_q;

    // flag copy is cleared by reset so a reset clear never looks like a software clear
    always_ff @(posedge sys_clk)
    begin
        flags_q <= any_rst ? TO_FLAGS_RST : st_r.flags_r;
        if (any_rst)
            run_len <= 5'h00;
        else if (ce)
            run_len <= (!tmo_run || tmo_restart || tmo_hit) ? 5'h00 : run_len + 5'h01;
    end

    assign fell_bits = flags_q & ~st_r.flags_r;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (any_rst);

    property p_count16;
        tmo_hit |-> run_len == 5'd15;
    endproperty
    a_count16: assert property (p_count16) else $error("time-out before 16 clocks"); // R1

    property p_off_no_tmo;
        !st_r.block_r[TIMEOUT_EN_BIT] |-> !tmo_hit;
    endproperty
    a_off_no_tmo: assert property (p_off_no_tmo) else $error("time-out while disabled"); // R2

    property p_flag_set;
        tmo_hit |=> (st_r.flags_r & $past(owner_onehot)) != 6'h00;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("time-out flag not set"); // R5

    property p_auto_blk;
        tmo_hit && st_r.block_r[AUTO_BLOCK_BIT] && !cfg_wr |=> (blk_eff & $past(owner_onehot)) != 6'h00;
    endproperty
    a_auto_blk: assert property (p_auto_blk) else $error("timed-out input not blocked"); // R3

    property p_no_blk_grant;
        bus_idle && owner_nxt != BRIDGE_ID |-> !blk_eff[owner_nxt];
    endproperty
    a_no_blk_grant: assert property (p_no_blk_grant) else $error("blocked input granted"); // R4

    property p_w1c;
        fell_bits != 6'h00 |-> $past(ce && cfg_wr && cfg_addr == ADDR_TO_FLAGS)
                            && (fell_bits & ~$past(cfg_wdata[5:0])) == 6'h00;
    endproperty
    a_w1c: assert property (p_w1c) else $error("flag cleared without write of one"); // R6

    property p_auto_hold;
        $past(st_r.block_r[AUTO_BLOCK_BIT]) |-> fell_bits == 6'h00;
    endproperty
    a_auto_hold: assert property (p_auto_hold) else $error("flag cleared under auto block"); // R7

    property p_rsvd;
        $past(ce && cfg_rd && cfg_addr == ADDR_TO_FLAGS) |-> cfg_rdata[7:6] == 2'b00;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved status bits nonzero"); // R8

    property p_reset_vals;
        $past(any_rst) |-> st_r.block_r == REQ_BLOCK_RST && st_r.flags_r == TO_FLAGS_RST;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("bits not cleared by reset"); // R9

    property p_tier_rst;
        $past(any_rst) |-> st_r.ctrl_r == ARB_CTRL_RST;
    endproperty
    a_tier_rst: assert property (p_tier_rst) else $error("tiers not high after reset"); // R11

    property p_hi_first;
        bus_idle && (req_all & tier_hi) != 7'h00 |-> tier_hi[owner_nxt];
    endproperty
    a_hi_first: assert property (p_hi_first) else $error("low tier beat high tier"); // R10

    property p_park;
        ce && bus_idle && req_all == 7'h00 && st_r.ctrl_r[PARK_BIT] |=> bridge_gnt;
    endproperty
    a_park: assert property (p_park) else $error("bus not parked on bridge"); // R12

    property p_frame_stops;
        !st_r.frame_s2_r |-> !tmo_hit;
    endproperty
    a_frame_stops: assert property (p_frame_stops) else $error("time-out during frame"); // R13

    c_timeout:   cover property (tmo_hit);
    c_auto_blk:  cover property (tmo_hit && st_r.block_r[AUTO_BLOCK_BIT]);
    c_clear:     cover property (fell_bits != 6'h00);
    c_park_brdg: cover property (bus_idle && req_all == 7'h00 && st_r.ctrl_r[PARK_BIT]);

endmodule // sec_bus_arbiter

// [sec_bus_masters.sv]
module sec_bus_masters
(
    // clock
    input  wire logic       sys_clk,
    // wishes of the test
    input  wire logic [5:0] want,
    input  wire logic [5:0] resp,
    // bus pins
    input  wire logic [5:0] gnt_n,
    output logic      [5:0] req_n,
    output logic            frame_n,
    output logic            irdy_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] busy_r;
    assign req_n = ~want;
    initial
    begin
        frame_n = 1'b1;
        irdy_n = 1'b1;
        busy_r = 2'h0;
    end
    // a silent master never drives FRAME; released lines are pulled high
    always @(posedge sys_clk)
    begin
        if (busy_r != 2'h0)
        begin
            busy_r <= busy_r - 2'h1;
            frame_n <= (busy_r == 2'h1);
            irdy_n <= (busy_r == 2'h1);
        end
        else if ((want & resp & ~gnt_n) != 6'h00)
        begin
            busy_r <= 2'h3;
            frame_n <= 1'b0;
            irdy_n <= 1'b0;
        end
    end
endmodule // sec_bus_masters

// [secondary_bus_arbiter_timeout_test.sv]
module secondary_bus_arbiter_timeout_test;
    import sec_arb_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk, rst, fund_reset_in, global_reset_in, por_reset_in;
    logic [5:0]  want, resp, req_n, gnt_n;
    logic        frame_n, irdy_n, bridge_gnt, cfg_wr, cfg_rd, ce, bridge_req;
    logic [7:0]  cfg_addr, cfg_wdata, cfg_rdata, m;
    logic [31:0] seed;
    int          errors, n_tests;
    ////////////////////////////////////////
    sec_bus_arbiter u_sec_bus_arbiter
    (
        .sys_clk(sys_clk), .rst(rst), .ce(ce), .fund_reset_in(fund_reset_in),
        .global_reset_in(global_reset_in), .por_reset_in(por_reset_in),
        .req_n(req_n), .frame_n(frame_n), .irdy_n(irdy_n), .gnt_n(gnt_n),
        .bridge_req(bridge_req), .bridge_gnt(bridge_gnt), .cfg_addr(cfg_addr),
        .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata)
    );
    sec_bus_masters u_sec_bus_masters
    (
        .sys_clk(sys_clk), .want(want), .resp(resp), .gnt_n(gnt_n),
        .req_n(req_n), .frame_n(frame_n), .irdy_n(irdy_n)
    );
    ////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic [7:0] flag_of(input int i);
        return 8'h01 << i;
    endfunction
    function automatic logic [7:0] blocked(input logic [5:0] g, input logic [7:0] b);
        return {2'b00, ~g & b[5:0]};
    endfunction
    task chk(input string s, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", s, e, g);
        end
    endtask
    task idle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        cfg_addr <= a;
        cfg_wdata <= d;
        cfg_wr <= 1'b1;
        @(posedge sys_clk);
        cfg_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        cfg_addr <= a;
        cfg_rd <= 1'b1;
        @(posedge sys_clk);
        cfg_rd <= 1'b0;
        #1;
        chk("cfg_rdata", e, cfg_rdata);
    endtask
    task done(input string s);
        $display("test %s done", s);
    endtask
    task end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    ////////////////////////////////////////
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // whole plan is about 500 cycles; this is far beyond it
    initial
    begin
        #200000;
        errors++;
        end_of_test;
    end
    initial
    begin
        {rst, fund_reset_in, global_reset_in, por_reset_in} = 4'h8;
        {cfg_wr, cfg_rd, cfg_addr, cfg_wdata} = 18'h0;
        {want, resp} = 12'h0;
        {ce, bridge_req} = 2'b10;
        seed = 32'd87177;
        errors = 0;
        n_tests = 0;
        idle(8);
        rst <= 1'b0;
        rd(ADDR_ARB_CTRL, 8'h7F);
        rd(ADDR_REQ_BLOCK, 8'h00);
        rd(ADDR_TO_FLAGS, 8'h00);
        rd(8'hDF, 8'h00);
        done("reset values");
        wr(ADDR_REQ_BLOCK, 8'h80);
        want <= 6'h04;
        idle(12);
        rd(ADDR_TO_FLAGS, 8'h00);
        // a frozen clock enable holds the count back by the frozen cycles
        ce <= 1'b0;
        idle(10);
        ce <= 1'b1;
        rd(ADDR_TO_FLAGS, 8'h00);
        idle(4);
        rd(ADDR_TO_FLAGS, flag_of(2));
        want <= 6'h00;
        idle(4);
        wr(ADDR_TO_FLAGS, 8'h00);
        rd(ADDR_TO_FLAGS, flag_of(2));
        wr(ADDR_TO_FLAGS, 8'hFF);
        rd(ADDR_TO_FLAGS, 8'h00);
        done("watchdog");
        wr(ADDR_REQ_BLOCK, 8'hC0);
        want <= 6'h08;
        idle(30);
        #1;
        chk("gnt_n", flag_of(3), {2'b00, gnt_n} & flag_of(3));
        rd(ADDR_TO_FLAGS, flag_of(3));
        want <= 6'h00;
        wr(ADDR_TO_FLAGS, 8'h08);
        rd(ADDR_TO_FLAGS, flag_of(3));
        wr(ADDR_REQ_BLOCK, 8'h80);
        wr(ADDR_TO_FLAGS, 8'h08);
        rd(ADDR_TO_FLAGS, 8'h00);
        done("auto block");
        // a busy master restarts the count, so no flag may appear
        want <= 6'h02;
        resp <= 6'h3F;
        idle(40);
        rd(ADDR_TO_FLAGS, 8'h00);
        wr(ADDR_REQ_BLOCK, 8'h00);
        resp <= 6'h00;
        idle(40);
        rd(ADDR_TO_FLAGS, 8'h00);
        // plain rotation after input 1 would pick input 4 or the bridge; the tiers pick 1
        wr(ADDR_ARB_CTRL, 8'h02);
        want <= 6'h12;
        bridge_req <= 1'b1;
        idle(8);
        #1;
        chk("gnt_n", 8'h02, {2'b00, ~gnt_n});
        wr(ADDR_ARB_CTRL, 8'h42);
        idle(4);
        #1;
        chk("bridge_gnt", 8'h01, {7'h0, bridge_gnt});
        wr(ADDR_ARB_CTRL, 8'h90);
        want <= 6'h00;
        bridge_req <= 1'b0;
        idle(8);
        #1;
        chk("bridge_gnt", 8'h01, {7'h0, bridge_gnt});
        done("tiers and parking");
        for (int i = 0; i < 16; i++)
        begin
            seed = xs(seed);
            m = {2'b00, seed[5:0]};
            wr(ADDR_REQ_BLOCK, m);
            want <= seed[13:8];
            resp <= seed[21:16];
            idle(8);
            repeat (4)
            begin
                @(posedge sys_clk);
                #1;
                chk("gnt_n", 8'h00, blocked(gnt_n, m));
            end
            rd(ADDR_REQ_BLOCK, m);
        end
        want <= 6'h00;
        done("random blocking");
        for (int k = 0; k < 3; k++)
        begin
            wr(ADDR_REQ_BLOCK, 8'hFF);
            wr(ADDR_ARB_CTRL, 8'h00);
            {fund_reset_in, global_reset_in, por_reset_in} <= 3'h4 >> k;
            idle(1);
            {fund_reset_in, global_reset_in, por_reset_in} <= 3'h0;
            rd(ADDR_REQ_BLOCK, 8'h00);
            rd(ADDR_ARB_CTRL, 8'h7F);
        end
        done("reset sources");
        end_of_test;
    end
endmodule // secondary_bus_arbiter_timeout_test
